// [hw/tssp_port.sv]
`timescale 1ns/1ps
`default_nettype none
// Contract
// (R1) Sample period setting 0x07 or below is fast mode, 0x08 up is normal.
// (R2) Host keeps serial clock 0.01 MHz to 2.5 fast or 1.0 MHz normal.
// (R3) Host spaces frame starts 40 us fast, 100 us normal.
// (R4) Output MSB appears on select falling, before any clock edge.
// (R5) Further output bits shift after serial clock falling edges.
// (R6) Input bit captured on serial clock rising edge.
// (R7) Output released to high impedance while select is high.
// (R8) Select active low; only activity inside select counts.
// (R9) Host may stretch select release delay beyond 5 ns for last bit.
// (R10) Active-low reset returns controller to initial state.
// (R11) Each frame is 16 clocks, 16 bits in and out full duplex.
// (R12) Write: 1, 0, 6-bit address, 8 data bits, one byte updated.
// (R13) Read: 0, 0, address, 8 ignored; 16-bit data next frame.
// (R14) Clock idles high; output on falling, input on rising edges.
module tssp_port (
  input  wire logic         CLK,
  input  wire logic         RST,
  input  wire logic         RST_N_PIN,
  input  wire logic         SCLK,
  input  wire logic         CS_N,
  input  wire logic         DIN,
  output logic              DOUT,
  output logic              DOUT_OE,
  output logic              WR_STB,
  output logic              RD_STB,
  output logic [5:0]        REG_ADDR,
  output logic [7:0]        WR_DATA,
  input  wire logic [15:0]  RD_DATA,
  output logic              FAST_MODE,
  output logic [7:0]        SAMPLE_PERIOD
);
  // Link domain: frame reset is select high, so no edges needed outside frames
  logic        link_rst;
  logic [3:0]  rx_cnt_q;
  logic [14:0] rx_sh_q;
  logic [15:0] rx_word_q;
  logic        rx_tgl_q;
  logic [3:0]  tx_pos_q;
  logic        tx_arm_q;
  logic [15:0] tx_hold;
  logic        dout_bit;

  assign link_rst = CS_N | RST; // (R8)

  always_ff @(posedge SCLK or posedge link_rst) begin
    if (link_rst) begin
      rx_cnt_q <= tssp_pkg::BIT_CNT_RST;
    end else begin
      rx_cnt_q <= rx_cnt_q + 4'h1; // (R11)
    end
  end

  always_ff @(posedge SCLK or posedge link_rst) begin
    if (link_rst) begin
      rx_sh_q <= tssp_pkg::RX_SH_RST;
    end else begin
      rx_sh_q <= {rx_sh_q[13:0], DIN}; // (R6)
    end
  end

  always_ff @(posedge SCLK or posedge RST) begin
    if (RST) begin
      rx_word_q <= tssp_pkg::RX_WORD_RST;
    end else if (!CS_N && rx_cnt_q == tssp_pkg::LAST_BIT) begin
      rx_word_q <= {rx_sh_q, DIN}; // (R11)
    end
  end

  always_ff @(posedge SCLK or posedge RST) begin
    if (RST) begin
      rx_tgl_q <= 1'b0;
    end else if (!CS_N && rx_cnt_q == tssp_pkg::LAST_BIT) begin
      rx_tgl_q <= ~rx_tgl_q;
    end
  end

  // First falling edge keeps the MSB put out at select fall
  always_ff @(negedge SCLK or posedge link_rst) begin
    if (link_rst) begin
      tx_arm_q <= 1'b0;
    end else begin
      tx_arm_q <= 1'b1; // (R14)
    end
  end

  always_ff @(negedge SCLK or posedge link_rst) begin
    if (link_rst) begin
      tx_pos_q <= tssp_pkg::BIT_CNT_RST; // (R4)
    end else if (tx_arm_q && tx_pos_q != tssp_pkg::LAST_BIT) begin
      tx_pos_q <= tx_pos_q + 4'h1; // (R5)
    end
  end

  // Held word loads read data only while synced select is high; pin reset clears it at any time
  always_comb begin
    dout_bit = tx_hold[tssp_pkg::LAST_BIT - tx_pos_q];
  end

  // Core domain
  logic [2:0]  tgl_sync_q;
  logic [2:0]  cs_sync_q;
  logic [2:0]  rstp_sync_q;
  logic [15:0] rx_cap_q;
  logic [15:0] tx_word_q;
  logic [7:0]  period_q;
  logic        wr_q;
  logic        rd_q;
  logic        rd_pend_q;
  logic [5:0]  addr_q;
  logic [7:0]  wdat_q;
  logic        frame_done;
  logic        ctrl_rst;
  logic        cs_high;
  logic        cs_low;

  function automatic logic is_write(input logic [15:0] w);
    return w[15:14] == tssp_pkg::WR_PREFIX;
  endfunction

  function automatic logic is_read(input logic [15:0] w);
    return w[15:14] == tssp_pkg::RD_PREFIX;
  endfunction

  assign tx_hold = tx_word_q;
  assign frame_done = tgl_sync_q[2] ^ tgl_sync_q[1];
  assign ctrl_rst = !rstp_sync_q[2] && !rstp_sync_q[1];
  assign cs_high = cs_sync_q[2] && cs_sync_q[1];
  assign cs_low = !cs_sync_q[2] && !cs_sync_q[1];

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tgl_sync_q <= tssp_pkg::SYNC_LO;
    end else begin
      tgl_sync_q <= {tgl_sync_q[1:0], rx_tgl_q};
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cs_sync_q <= tssp_pkg::SYNC_HI;
    end else begin
      cs_sync_q <= {cs_sync_q[1:0], CS_N};
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rstp_sync_q <= tssp_pkg::SYNC_HI;
    end else begin
      rstp_sync_q <= {rstp_sync_q[1:0], RST_N_PIN};
    end
  end

  // Word is stable here: toggle seen two stages late, frame over
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rx_cap_q <= 16'h0000;
    end else if (frame_done) begin
      rx_cap_q <= rx_word_q;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wr_q <= 1'b0;
    end else if (ctrl_rst) begin
      wr_q <= 1'b0; // (R10)
    end else begin
      wr_q <= frame_done && is_write(rx_word_q); // (R12)
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rd_q <= 1'b0;
    end else if (ctrl_rst) begin
      rd_q <= 1'b0; // (R10)
    end else begin
      rd_q <= frame_done && is_read(rx_word_q); // (R13)
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      addr_q <= tssp_pkg::ADDR_RST;
    end else if (ctrl_rst) begin
      addr_q <= tssp_pkg::ADDR_RST; // (R10)
    end else if (frame_done) begin
      addr_q <= rx_word_q[13:8]; // (R12)
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wdat_q <= tssp_pkg::WDAT_RST;
    end else if (ctrl_rst) begin
      wdat_q <= tssp_pkg::WDAT_RST; // (R10)
    end else if (frame_done) begin
      wdat_q <= rx_word_q[7:0]; // (R12)
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      period_q <= tssp_pkg::SAMPLE_PERIOD_RST;
    end else if (ctrl_rst) begin
      period_q <= tssp_pkg::SAMPLE_PERIOD_RST; // (R10)
    end else if (frame_done && is_write(rx_word_q)
                 && rx_word_q[13:8] == tssp_pkg::PERIOD_ADDR) begin
      period_q <= rx_word_q[7:0]; // (R12)
    end
  end

  // Read stays pending until the next frame starts
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rd_pend_q <= 1'b0;
    end else if (ctrl_rst) begin
      rd_pend_q <= 1'b0; // (R10)
    end else if (frame_done && is_read(rx_word_q)) begin
      rd_pend_q <= 1'b1; // (R13)
    end else if (cs_low) begin
      rd_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tx_word_q <= tssp_pkg::TX_RST;
    end else if (ctrl_rst) begin
      tx_word_q <= tssp_pkg::TX_RST; // (R10)
    end else if (rd_pend_q && cs_high) begin
      tx_word_q <= RD_DATA; // (R13)
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      FAST_MODE <= 1'b0;
    end else begin
      FAST_MODE <= (period_q <= tssp_pkg::FAST_MODE_MAX); // (R1)
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      WR_STB <= 1'b0;
    end else begin
      WR_STB <= wr_q;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RD_STB <= 1'b0;
    end else begin
      RD_STB <= rd_q;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      REG_ADDR <= tssp_pkg::ADDR_RST;
    end else begin
      REG_ADDR <= addr_q;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      WR_DATA <= tssp_pkg::WDAT_RST;
    end else begin
      WR_DATA <= wdat_q;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      SAMPLE_PERIOD <= tssp_pkg::SAMPLE_PERIOD_RST;
    end else begin
      SAMPLE_PERIOD <= period_q;
    end
  end

  // DOUT picks a bit of the core held word by the link bit position; enable follows select directly
  always_comb begin
    DOUT    = dout_bit;
    DOUT_OE = !CS_N && !RST; // (R7)
  end
endmodule
`default_nettype wire

// [common/tssp_pkg.sv]
`default_nettype none
package tssp_pkg;
  localparam int unsigned   FRAME_BITS        = 16;
  localparam int unsigned   ADDR_BITS         = 6;
  localparam int unsigned   DATA_BITS         = 8;
  localparam logic [7:0]    FAST_MODE_MAX     = 8'h07;
  localparam logic [7:0]    SAMPLE_PERIOD_RST = 8'h0A;
  localparam logic [15:0]   TX_RST            = 16'h0000;
  localparam logic [3:0]    BIT_CNT_RST       = 4'h0;
  localparam logic [3:0]    LAST_BIT          = 4'hF;
  localparam logic [14:0]   RX_SH_RST         = 15'h0000;
  localparam logic [15:0]   RX_WORD_RST       = 16'h0000;
  localparam logic [5:0]    ADDR_RST          = 6'h00;
  localparam logic [7:0]    WDAT_RST          = 8'h00;
  localparam logic [5:0]    PERIOD_ADDR       = 6'h00;
  localparam logic [2:0]    SYNC_LO           = 3'h0;
  localparam logic [2:0]    SYNC_HI           = 3'h7;
  localparam logic [1:0]    WR_PREFIX         = 2'h2;
  localparam logic [1:0]    RD_PREFIX         = 2'h0;
  localparam int unsigned   SCLK_MIN_KHZ      = 10;
  localparam int unsigned   SCLK_FAST_MAX_KHZ = 2500;
  localparam int unsigned   SCLK_NORM_MAX_KHZ = 1000;
  localparam int unsigned   FRAME_FAST_US     = 40;
  localparam int unsigned   FRAME_NORM_US     = 100;
  localparam int unsigned   SEL_RELEASE_NS    = 5;
  localparam int unsigned   CLK_MHZ           = 50;
  localparam int unsigned   FRAME_FAST_CYC    = FRAME_FAST_US * CLK_MHZ;
  localparam int unsigned   FRAME_NORM_CYC    = FRAME_NORM_US * CLK_MHZ;
endpackage
`default_nettype wire

// [verification/tssp_port_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module tssp_chk (
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       CS_N,
  input wire logic       DOUT_OE,
  input wire logic       WR_STB,
  input wire logic       RD_STB,
  input wire logic       FAST_MODE,
  input wire logic [7:0] SAMPLE_PERIOD
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  AST_OE_OFF: assert property (CS_N |-> !DOUT_OE) else $error("oe on");
  AST_OE_ON: assert property (!CS_N |-> DOUT_OE) else $error("oe off");
  AST_MODE: assert property ($stable(SAMPLE_PERIOD) [*2] |->
    FAST_MODE == (SAMPLE_PERIOD < 8'h08)) else $error("mode");
  AST_WR_ONE: assert property (WR_STB |=> !WR_STB) else $error("wr");
  AST_RD_ONE: assert property (RD_STB |=> !RD_STB) else $error("rd");
  AST_ONE_KIND: assert property (!(WR_STB && RD_STB)) else $error("both");
  AST_AFTER: assert property ((WR_STB || RD_STB) |-> $past(CS_N, 2)) else $error("early");
  AST_FAST_SRC: assert property ($rose(FAST_MODE) |->
    WR_STB || $past(WR_STB) || $past(WR_STB, 2)) else $error("fast");
endmodule
bind tssp_port tssp_chk chk_u (.CLK(CLK), .RST(RST), .CS_N(CS_N), .DOUT_OE(DOUT_OE),
  .WR_STB(WR_STB), .RD_STB(RD_STB), .FAST_MODE(FAST_MODE), .SAMPLE_PERIOD(SAMPLE_PERIOD));
`default_nettype wire

// [verification/tssp_host.sv]
`timescale 1ns/1ps
`default_nettype none
module tssp_host (
  output logic     sclk,
  output logic     cs_n,
  output logic     din,
  input wire logic dout
);
  initial {sclk, cs_n, din} = 3'h6;
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    #100000 cs_n = 1'h0;
    for (int i = 15; i >= 0; i--) begin
      #16 {sclk, din} = {1'h0, tx[i]};
      #16 {rx[i], sclk} = {dout, 1'h1};
    end
    #16 {cs_n, din} = {1'h1, ~din};
  endtask
endmodule
`default_nettype wire

// [verification/tssp_port_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tssp_port_tb_top;
  logic        clk = 1'h0, rst = 1'h1, pin_n = 1'h1, sclk, cs_n, din, dout, oe, wr, rd, fm;
  logic [7:0]  wd, sp;
  logic [5:0]  ra;
  logic [15:0] rdat = 16'hA5C3, rx;
  int          n_errors = 0, n_tests = 0;
  tssp_port dut_u (.CLK(clk), .RST(rst), .RST_N_PIN(pin_n), .SCLK(sclk), .CS_N(cs_n),
    .DIN(din), .DOUT(dout), .DOUT_OE(oe), .WR_STB(wr), .RD_STB(rd), .REG_ADDR(ra),
    .WR_DATA(wd), .RD_DATA(rdat), .FAST_MODE(fm), .SAMPLE_PERIOD(sp));
  tssp_host host_u (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
  initial forever #10 clk = ~clk;
  task automatic chk(input string n, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) $display("BAD %s exp %h got %h", n, e, g);
    n_errors += int'(g !== e);
  endtask
  task automatic test_done;
    if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic frame(input logic [15:0] tx, input logic [1:0] stb);
    logic [1:0] s = 2'h0;
    host_u.xfer(tx, rx);
    repeat (20) @(negedge clk) s |= {wr, rd};
    chk("stb", 16'(stb), 16'(s));
    if (stb) chk("ad", 16'(tx[13:8]), 16'(ra));
  endtask
  task automatic t_idle;
    repeat (6) @(posedge clk);
    chk("sp", 16'h000A, 16'(sp));
    chk("oe", 16'h0000, 16'(oe));
  endtask
  task automatic t_write(input logic [7:0] v);
    frame({8'h80, v}, 2'h2);
    chk("wd", 16'(v), 16'(wd));
    chk("fm", 16'(v < 8'h08), 16'(fm));
  endtask
  task automatic t_read;
    frame(16'hC1FF, 2'h0);
    frame(16'h05FF, 2'h1);
    frame(16'h0000, 2'h1);
    chk("rx", 16'hA5C3, rx);
  endtask
  task automatic t_pin;
    pin_n <= 1'h0;
    repeat (8) @(posedge clk);
    pin_n <= 1'h1;
    t_idle;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    t_idle;
    t_write(8'h07);
    t_write(8'h08);
    t_read;
    t_pin;
    test_done;
  end
endmodule
`default_nettype wire
